/* File: rtl/cdhp_defines.svh */
// Purpose: constants of the nibble handshake port shared by both ends
// Assumes: 100 MHz system clock
// Notes:   times are kept in milliseconds, cycle counts derive from them
`ifndef CDHP_DEFINES_SVH
`define CDHP_DEFINES_SVH

`define CDHP_NIB_W          4
`define CDHP_TIMER_W        19
`define CDHP_CLK_KHZ        100000
// controller answers each host strobe within this time
`define CDHP_DEV_RESP_MS    1
// host answers a controller send request within this time
`define CDHP_HOST_RESP_MS   5
`define CDHP_DEV_RESP_CYC   (`CDHP_DEV_RESP_MS * `CDHP_CLK_KHZ)
`define CDHP_HOST_RESP_CYC  (`CDHP_HOST_RESP_MS * `CDHP_CLK_KHZ)

`endif

/* File: rtl/cdhp_pkg.sv */
// Purpose: types of the nibble handshake port
// Assumes: cdhp_defines.svh gives the widths
// Notes:   state codes are left to the tools
`include "cdhp_defines.svh"

package cdhp_pkg;

  typedef logic [`CDHP_NIB_W-1:0]   cdhp_nib_t;
  typedef logic [`CDHP_TIMER_W-1:0] cdhp_timer_t;

  typedef enum logic [2:0] {
    DEV_IDLE,
    DEV_RX,
    DEV_RX_HOLD,
    DEV_TX_MARK,
    DEV_TX_WAIT,
    DEV_TX_NEXT
  } cdhp_dev_state_t;

  typedef enum logic [2:0] {
    HST_IDLE,
    HST_CMD_MARK,
    HST_CMD_WAIT,
    HST_CMD_NEXT,
    HST_CMD_READY,
    HST_RD_WAIT,
    HST_RD_REL
  } cdhp_host_state_t;

endpackage

/* File: rtl/cdhp_link_if.sv */
// Purpose: open-drain link between controller and host
// Assumes: every line has a pull-up; a party pulls low by raising its enable
// Notes:   the resolved lines are what both ends sample
`timescale 1ns/1ps

interface cdhp_link_if;

  logic             devReqOut;
  logic             devReqOe;
  logic             devAckOut;
  logic             devAckOe;
  cdhp_pkg::cdhp_nib_t devNibOut;
  cdhp_pkg::cdhp_nib_t devNibOe;
  logic             hostReqOut;
  logic             hostReqOe;
  logic             hostStbOut;
  logic             hostStbOe;
  cdhp_pkg::cdhp_nib_t hostNibOut;
  cdhp_pkg::cdhp_nib_t hostNibOe;

  logic             reqLine;
  logic             stbLine;
  logic             ackLine;
  cdhp_pkg::cdhp_nib_t nibLine;

  // wired-and of the drivers over the pull-up; strobe and reply each have one driver
  assign reqLine = (devReqOe ? devReqOut : 1'b1) & (hostReqOe ? hostReqOut : 1'b1);
  assign stbLine = hostStbOe ? hostStbOut : 1'b1;
  assign ackLine = devAckOe ? devAckOut : 1'b1;
  assign nibLine = ((devNibOut | ~devNibOe) & (hostNibOut | ~hostNibOe));

  modport device (
    input  reqLine,
    input  stbLine,
    input  ackLine,
    input  nibLine,
    output devReqOut,
    output devReqOe,
    output devAckOut,
    output devAckOe,
    output devNibOut,
    output devNibOe
  );

  modport host (
    input  reqLine,
    input  stbLine,
    input  ackLine,
    input  nibLine,
    output hostReqOut,
    output hostReqOe,
    output hostStbOut,
    output hostStbOe,
    output hostNibOut,
    output hostNibOe
  );

endinterface // cdhp_link_if

/* File: rtl/cdhp_device_end.sv */
// Purpose: controller end of the nibble handshake port, plus home sense
// Assumes: link lines and homeIn are synchronous to clk
// Notes:   drivers only ever pull low; a one means released
`timescale 1ns/1ps
`include "cdhp_defines.svh"

module cdhp_device_end #(
  parameter logic [`CDHP_TIMER_W-1:0] HostWaitCycles = `CDHP_TIMER_W'(`CDHP_HOST_RESP_CYC)
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  cdhp_link_if.device               link,
  input  wire cdhp_pkg::cdhp_nib_t  txData,
  input  wire logic                 txLast,
  input  wire logic                 txValid,
  output      logic                 txReady,
  output      cdhp_pkg::cdhp_nib_t  rxData,
  output      logic                 rxLast,
  output      logic                 rxValid,
  output      logic                 busy,
  output      logic                 timeout,
  input  wire logic                 homeIn,
  output      logic                 homeFound
);

  cdhp_pkg::cdhp_dev_state_t state_q;
  cdhp_pkg::cdhp_dev_state_t stateLast_q;
  cdhp_pkg::cdhp_timer_t     timer_q;
  cdhp_pkg::cdhp_nib_t       nibOe_q;
  cdhp_pkg::cdhp_nib_t       rxData_q;
  logic                      reqOe_q;
  logic                      ackOe_q;
  logic                      last_q;
  logic                      reqPrev_q;
  logic                      stbPrev_q;
  logic                      homePrev_q;
  logic                      txReady_q;
  logic                      rxLast_q;
  logic                      rxValid_q;
  logic                      busy_q;
  logic                      timeout_q;
  logic                      homeFound_q;
  logic                      reqFall;
  logic                      stbRise;
  logic                      stbFall;
  logic                      timeUp;

  //////////////////////////////////////////////////////////////////////////////
  // line edges

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reqPrev_q <= 1'b1;
      stbPrev_q <= 1'b1;
    end else begin
      reqPrev_q <= link.reqLine;
      stbPrev_q <= link.stbLine;
    end
  end

  assign reqFall = reqPrev_q & ~link.reqLine;
  assign stbRise = ~stbPrev_q & link.stbLine;
  assign stbFall = stbPrev_q & ~link.stbLine;

  //////////////////////////////////////////////////////////////////////////////
  // response deadline, restarted on every step of a session

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_q     <= '0;
      stateLast_q <= cdhp_pkg::DEV_IDLE;
    end else begin
      stateLast_q <= state_q;
      if (state_q == cdhp_pkg::DEV_IDLE || state_q != stateLast_q) begin
        timer_q <= '0;
      end else if (!timeUp) begin
        timer_q <= timer_q + 1'b1;
      end
    end
  end

  assign timeUp = (timer_q == HostWaitCycles - 1'b1);

  //////////////////////////////////////////////////////////////////////////////
  // session sequencer

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= cdhp_pkg::DEV_IDLE;
      reqOe_q   <= 1'b0;
      ackOe_q   <= 1'b0;
      nibOe_q   <= '0;
      last_q    <= 1'b0;
      txReady_q <= 1'b0;
      rxData_q  <= '0;
      rxLast_q  <= 1'b0;
      rxValid_q <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      txReady_q <= 1'b0;
      rxValid_q <= 1'b0;
      timeout_q <= 1'b0;
      if (state_q != cdhp_pkg::DEV_IDLE && timeUp) begin
        // give up: release everything so the lines float high
        reqOe_q   <= 1'b0;
        ackOe_q   <= 1'b0;
        nibOe_q   <= '0;
        timeout_q <= 1'b1;
        state_q   <= cdhp_pkg::DEV_IDLE;
      end else begin
        case (state_q)
          cdhp_pkg::DEV_IDLE: begin
            if (reqFall && !link.ackLine) begin
              state_q <= cdhp_pkg::DEV_RX;
            end else if (txValid && !ackOe_q && link.reqLine && !reqFall) begin
              // reply already high: first nibble goes out with request low
              nibOe_q   <= ~txData;
              reqOe_q   <= 1'b1;
              last_q    <= txLast;
              txReady_q <= 1'b1;
              state_q   <= cdhp_pkg::DEV_TX_MARK;
            end else begin
              // reply low means ready for a command, high means send pending
              ackOe_q <= ~txValid;
            end
          end
          cdhp_pkg::DEV_RX: begin
            if (stbRise) begin
              rxData_q  <= link.nibLine;
              rxLast_q  <= link.reqLine;
              rxValid_q <= 1'b1;
              ackOe_q   <= 1'b0;
              state_q   <= link.reqLine ? cdhp_pkg::DEV_IDLE : cdhp_pkg::DEV_RX_HOLD;
            end
          end
          cdhp_pkg::DEV_RX_HOLD: begin
            if (stbFall) begin
              ackOe_q <= 1'b1;
              state_q <= cdhp_pkg::DEV_RX;
            end
          end
          cdhp_pkg::DEV_TX_MARK: begin
            ackOe_q <= 1'b1;
            reqOe_q <= ~last_q;
            state_q <= cdhp_pkg::DEV_TX_WAIT;
          end
          cdhp_pkg::DEV_TX_WAIT: begin
            if (stbRise) begin
              ackOe_q <= 1'b0;
              nibOe_q <= '0;
              state_q <= last_q ? cdhp_pkg::DEV_IDLE : cdhp_pkg::DEV_TX_NEXT;
            end
          end
          cdhp_pkg::DEV_TX_NEXT: begin
            if (txValid) begin
              nibOe_q   <= ~txData;
              last_q    <= txLast;
              txReady_q <= 1'b1;
              state_q   <= cdhp_pkg::DEV_TX_MARK;
            end
          end
          default: begin
            reqOe_q <= 1'b0;
            ackOe_q <= 1'b0;
            nibOe_q <= '0;
            state_q <= cdhp_pkg::DEV_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q != cdhp_pkg::DEV_IDLE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // home switch sense

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      homePrev_q  <= 1'b1;
      homeFound_q <= 1'b0;
    end else begin
      homePrev_q  <= homeIn;
      homeFound_q <= ~homePrev_q & homeIn;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.devReqOut = 1'b0;
  assign link.devAckOut = 1'b0;
  assign link.devNibOut = '0;
  assign link.devReqOe  = reqOe_q;
  assign link.devAckOe  = ackOe_q;
  assign link.devNibOe  = nibOe_q;
  assign txReady        = txReady_q;
  assign rxData         = rxData_q;
  assign rxLast         = rxLast_q;
  assign rxValid        = rxValid_q;
  assign busy           = busy_q;
  assign timeout        = timeout_q;
  assign homeFound      = homeFound_q;

endmodule // cdhp_device_end

/* File: rtl/cdhp_host_end.sv */
// Purpose: host end of the nibble handshake port
// Assumes: link lines are synchronous to clk
// Notes:   answers controller send requests at once
`timescale 1ns/1ps
`include "cdhp_defines.svh"

module cdhp_host_end #(
  parameter logic [`CDHP_TIMER_W-1:0] DevWaitCycles = `CDHP_TIMER_W'(`CDHP_DEV_RESP_CYC)
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  cdhp_link_if.host                 link,
  input  wire cdhp_pkg::cdhp_nib_t  cmdData,
  input  wire logic                 cmdLast,
  input  wire logic                 cmdValid,
  output      logic                 cmdReady,
  output      cdhp_pkg::cdhp_nib_t  rdData,
  output      logic                 rdLast,
  output      logic                 rdValid,
  output      logic                 busy,
  output      logic                 timeout
);

  cdhp_pkg::cdhp_host_state_t state_q;
  cdhp_pkg::cdhp_host_state_t stateLast_q;
  cdhp_pkg::cdhp_timer_t      timer_q;
  cdhp_pkg::cdhp_nib_t        nibOe_q;
  cdhp_pkg::cdhp_nib_t        rdData_q;
  logic                       reqOe_q;
  logic                       stbOe_q;
  logic                       last_q;
  logic                       reqPrev_q;
  logic                       cmdReady_q;
  logic                       rdLast_q;
  logic                       rdValid_q;
  logic                       busy_q;
  logic                       timeout_q;
  logic                       reqFall;
  logic                       timeUp;

  //////////////////////////////////////////////////////////////////////////////
  // request edge and deadline

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reqPrev_q   <= 1'b1;
      timer_q     <= '0;
      stateLast_q <= cdhp_pkg::HST_IDLE;
    end else begin
      reqPrev_q   <= link.reqLine;
      stateLast_q <= state_q;
      if (state_q == cdhp_pkg::HST_IDLE || state_q != stateLast_q) begin
        timer_q <= '0;
      end else if (!timeUp) begin
        timer_q <= timer_q + 1'b1;
      end
    end
  end

  assign reqFall = reqPrev_q & ~link.reqLine;
  assign timeUp  = (timer_q == DevWaitCycles - 1'b1);

  //////////////////////////////////////////////////////////////////////////////
  // session sequencer

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q    <= cdhp_pkg::HST_IDLE;
      reqOe_q    <= 1'b0;
      stbOe_q    <= 1'b0;
      nibOe_q    <= '0;
      last_q     <= 1'b0;
      cmdReady_q <= 1'b0;
      rdData_q   <= '0;
      rdLast_q   <= 1'b0;
      rdValid_q  <= 1'b0;
      timeout_q  <= 1'b0;
      busy_q     <= 1'b0;
    end else begin
      cmdReady_q <= 1'b0;
      rdValid_q  <= 1'b0;
      timeout_q  <= 1'b0;
      if (state_q != cdhp_pkg::HST_IDLE && timeUp) begin
        reqOe_q   <= 1'b0;
        stbOe_q   <= 1'b0;
        nibOe_q   <= '0;
        timeout_q <= 1'b1;
        state_q   <= cdhp_pkg::HST_IDLE;
      end else begin
        case (state_q)
          cdhp_pkg::HST_IDLE: begin
            if (reqFall && link.ackLine) begin
              stbOe_q <= 1'b1;
              state_q <= cdhp_pkg::HST_RD_WAIT;
            end else if (cmdValid && !link.ackLine && link.reqLine && !reqFall) begin
              nibOe_q    <= ~cmdData;
              reqOe_q    <= 1'b1;
              stbOe_q    <= 1'b1;
              last_q     <= cmdLast;
              cmdReady_q <= 1'b1;
              state_q    <= cdhp_pkg::HST_CMD_MARK;
            end
          end
          cdhp_pkg::HST_CMD_MARK: begin
            stbOe_q <= 1'b0;
            reqOe_q <= ~last_q;
            state_q <= cdhp_pkg::HST_CMD_WAIT;
          end
          cdhp_pkg::HST_CMD_WAIT: begin
            if (link.ackLine) begin
              nibOe_q <= '0;
              state_q <= last_q ? cdhp_pkg::HST_IDLE : cdhp_pkg::HST_CMD_NEXT;
            end
          end
          cdhp_pkg::HST_CMD_NEXT: begin
            if (cmdValid) begin
              nibOe_q    <= ~cmdData;
              stbOe_q    <= 1'b1;
              last_q     <= cmdLast;
              cmdReady_q <= 1'b1;
              state_q    <= cdhp_pkg::HST_CMD_READY;
            end
          end
          cdhp_pkg::HST_CMD_READY: begin
            if (!link.ackLine) begin
              state_q <= cdhp_pkg::HST_CMD_MARK;
            end
          end
          cdhp_pkg::HST_RD_WAIT: begin
            if (!link.ackLine) begin
              rdData_q  <= link.nibLine;
              rdLast_q  <= link.reqLine;
              rdValid_q <= 1'b1;
              stbOe_q   <= 1'b0;
              state_q   <= cdhp_pkg::HST_RD_REL;
            end
          end
          cdhp_pkg::HST_RD_REL: begin
            if (link.ackLine) begin
              stbOe_q <= ~rdLast_q;
              state_q <= rdLast_q ? cdhp_pkg::HST_IDLE : cdhp_pkg::HST_RD_WAIT;
            end
          end
          default: begin
            reqOe_q <= 1'b0;
            stbOe_q <= 1'b0;
            nibOe_q <= '0;
            state_q <= cdhp_pkg::HST_IDLE;
          end
        endcase
      end
      busy_q <= (state_q != cdhp_pkg::HST_IDLE);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign link.hostReqOut = 1'b0;
  assign link.hostStbOut = 1'b0;
  assign link.hostNibOut = '0;
  assign link.hostReqOe  = reqOe_q;
  assign link.hostStbOe  = stbOe_q;
  assign link.hostNibOe  = nibOe_q;
  assign cmdReady        = cmdReady_q;
  assign rdData          = rdData_q;
  assign rdLast          = rdLast_q;
  assign rdValid         = rdValid_q;
  assign busy            = busy_q;
  assign timeout         = timeout_q;

endmodule // cdhp_host_end

/* File: bench/cdhp_link_assertions.sv */
// Purpose: concurrent checks on the nibble handshake link
// Assumes: lines resolved inside the link, one clock domain
// Notes:   instantiated by the bench top beside the link
`timescale 1ns/1ps

module cdhp_link_assertions (
  input wire logic                clk,
  input wire logic                rst_b,
  input wire logic                reqLine,
  input wire logic                stbLine,
  input wire logic                ackLine,
  input wire cdhp_pkg::cdhp_nib_t nibLine,
  input wire logic                devReqOe,
  input wire logic                hostReqOe,
  input wire cdhp_pkg::cdhp_nib_t devNibOe,
  input wire cdhp_pkg::cdhp_nib_t hostNibOe
);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  //////////////////////////////////////////////////////////////////////////////
  reset_idle_a: assert property ($rose(rst_b) |-> reqLine && stbLine && ackLine && (nibLine == 4'hf))
    else $error("link lines not idle after reset");
  strobe_in_session_a: assert property ($fell(stbLine) |-> !reqLine || !$past(reqLine))
    else $error("strobe moved outside a session");
  cmd_dir_a: assert property ($fell(reqLine) && !ackLine |-> devNibOe == 4'h0)
    else $error("controller drove bus in command session");
  send_dir_a: assert property ($fell(reqLine) && ackLine |-> hostNibOe == 4'h0)
    else $error("host drove bus in send session");
  strobe_answer_a: assert property ($fell(stbLine) |-> ##[0:3] !ackLine)
    else $error("reply did not follow strobe fall");
  host_answer_a: assert property ($fell(reqLine) && ackLine |-> ##[0:3] !stbLine)
    else $error("host did not answer send request");
  ack_after_strobe_a: assert property ($rose(stbLine) |=> ackLine)
    else $error("reply not released after strobe rise");
  last_marker_a: assert property ($rose(reqLine) |-> $rose(stbLine) || $fell(ackLine))
    else $error("request rose without a nibble mark");
  one_driver_a: assert property (!((devNibOe != 4'h0) && (hostNibOe != 4'h0)) && !(devReqOe && hostReqOe))
    else $error("both ends drove the link at once");

  //////////////////////////////////////////////////////////////////////////////
  cover property ($fell(reqLine) && !ackLine);
  cover property ($fell(reqLine) && ackLine);
  cover property ($rose(reqLine) && $rose(stbLine));

endmodule // cdhp_link_assertions

/* File: bench/cd_controller_host_handshake_port_tb.sv */
// Purpose: self-checking bench of both link ends joined back to back
// Assumes: deadlines shortened to 64 cycles
// Notes:   a second link has a silent host to force a controller timeout,
//          a third a ready but silent controller to force a host timeout
`timescale 1ns/1ps

module cd_controller_host_handshake_port_tb;

  logic                clk, rst_b, homeIn, cmdLast, cmdValid, txLast, txValid, tx2Last, tx2Valid;
  cdhp_pkg::cdhp_nib_t cmdData, txData, tx2Data, rxData, rdData;
  logic                cmdReady, txReady, rxLast, rxValid, rdLast, rdValid, homeFound;
  logic                devBusy, hostBusy, devTimeout, hostTimeout, dev2Timeout;
  logic                cmd2Valid, host2Timeout;
  logic [4:0]          cmdQ[$], txQ[$];
  logic [31:0]         rnd;
  int                  errors, checked, homeCnt, i, d, s, k;

  cdhp_link_if linkA ();
  cdhp_link_if linkB ();
  cdhp_link_if linkC ();

  // controller on the third link shows ready but never answers a strobe
  assign linkC.devReqOut = 1'b0;
  assign linkC.devReqOe  = 1'b0;
  assign linkC.devAckOut = 1'b0;
  assign linkC.devAckOe  = 1'b1;
  assign linkC.devNibOut = 4'h0;
  assign linkC.devNibOe  = 4'h0;

  // silent host on the second link: every line left to its pull-up
  assign linkB.hostReqOut = 1'b0;
  assign linkB.hostReqOe  = 1'b0;
  assign linkB.hostStbOut = 1'b0;
  assign linkB.hostStbOe  = 1'b0;
  assign linkB.hostNibOut = 4'h0;
  assign linkB.hostNibOe  = 4'h0;

  cdhp_device_end #(.HostWaitCycles(19'h40)) u_cdhp_device_end (
    .clk(clk), .rst_b(rst_b), .link(linkA), .txData(txData), .txLast(txLast), .txValid(txValid),
    .txReady(txReady), .rxData(rxData), .rxLast(rxLast), .rxValid(rxValid), .busy(devBusy),
    .timeout(devTimeout), .homeIn(homeIn), .homeFound(homeFound));

  cdhp_host_end #(.DevWaitCycles(19'h40)) u_cdhp_host_end (
    .clk(clk), .rst_b(rst_b), .link(linkA), .cmdData(cmdData), .cmdLast(cmdLast), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .rdData(rdData), .rdLast(rdLast), .rdValid(rdValid), .busy(hostBusy),
    .timeout(hostTimeout));

  cdhp_device_end #(.HostWaitCycles(19'h40)) u_cdhp_device_end_2 (
    .clk(clk), .rst_b(rst_b), .link(linkB), .txData(tx2Data), .txLast(tx2Last), .txValid(tx2Valid),
    .txReady(), .rxData(), .rxLast(), .rxValid(), .busy(), .timeout(dev2Timeout), .homeIn(1'b0),
    .homeFound());

  cdhp_host_end #(.DevWaitCycles(19'h40)) u_cdhp_host_end_2 (
    .clk(clk), .rst_b(rst_b), .link(linkC), .cmdData(tx2Data), .cmdLast(tx2Last), .cmdValid(cmd2Valid),
    .cmdReady(), .rdData(), .rdLast(), .rdValid(), .busy(), .timeout(host2Timeout));

  cdhp_link_assertions u_cdhp_link_assertions (
    .clk(clk), .rst_b(rst_b), .reqLine(linkA.reqLine), .stbLine(linkA.stbLine), .ackLine(linkA.ackLine),
    .nibLine(linkA.nibLine), .devReqOe(linkA.devReqOe), .hostReqOe(linkA.hostReqOe),
    .devNibOe(linkA.devNibOe), .hostNibOe(linkA.hostNibOe));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic stall();
    errors++;
    $display("unexpected wait expected handshake seen none");
    results();
  endtask

  // hands one nibble to the sending end and notes what the far end must show
  task automatic put(input logic toDev, input cdhp_pkg::cdhp_nib_t nib, input logic last);
    int n;
    if (toDev) begin
      cmdData = nib;
      cmdLast = last;
      cmdValid = 1'b1;
      cmdQ.push_back({last, nib});
    end else begin
      txData = nib;
      txLast = last;
      txValid = 1'b1;
      txQ.push_back({last, nib});
    end
    for (n = 0; n < 300; n++) begin
      @(negedge clk);
      if ((toDev ? cmdReady : txReady) === 1'b1) break;
    end
    if (n == 300) stall();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(negedge clk) begin
    if (rst_b === 1'b1) begin
      if (rxValid === 1'b1) check("rx nibble", 8'({rxLast, rxData}), 8'(cmdQ.size() ? cmdQ.pop_front() : 'x));
      if (rdValid === 1'b1) check("rd nibble", 8'({rdLast, rdData}), 8'(txQ.size() ? txQ.pop_front() : 'x));
      if (homeFound === 1'b1) homeCnt++;
      if ({devTimeout, hostTimeout} !== 2'b00) check("link timeout", 8'({devTimeout, hostTimeout}), 8'h0);
    end
  end

  initial begin
    rst_b = 1'b0;
    homeIn = 1'b1;
    {cmdData, cmdLast, cmdValid, txData, txLast, txValid, tx2Data, tx2Last, tx2Valid, cmd2Valid} = '0;
    rnd = 32'h19;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    // home switch already high at reset must not count
    repeat (3) @(negedge clk);
    check("home count", 8'(homeCnt), 8'h0);
    homeIn = 1'b0;
    repeat (3) @(negedge clk);
    homeIn = 1'b1;
    repeat (3) @(negedge clk);
    check("home count", 8'(homeCnt), 8'h1);
    homeIn = 1'b0;
    repeat (3) @(negedge clk);
    check("home count", 8'(homeCnt), 8'h1);
    $display("test home done");
    // d 0: commands to the controller, d 1: data to the host; strings of 1 to 4
    for (d = 0; d < 2; d++) begin
      for (s = 0; s < 4; s++) begin
        for (k = 0; k <= s; k++) begin
          rnd = xs(rnd);
          put(d == 0, rnd[3:0], k == s);
        end
        cmdValid = 1'b0;
        txValid = 1'b0;
        for (i = 0; i < 300 && (cmdQ.size() || txQ.size()); i++) @(negedge clk);
        if (i == 300) stall();
        repeat (4) @(negedge clk);
        check("ends busy", 8'({devBusy, hostBusy}), 8'h0);
      end
      $display("test strings %0d done", d);
    end
    // host never answers the send request on the second link
    tx2Data = rnd[7:4];
    tx2Last = 1'b1;
    tx2Valid = 1'b1;
    for (i = 0; i < 300 && dev2Timeout !== 1'b1; i++) @(negedge clk);
    check("timeout seen", 8'(dev2Timeout), 8'h1);
    check("timeout early", 8'(i >= 64), 8'h1);
    check("lines released", 8'({linkB.reqLine, linkB.ackLine, linkB.nibLine}), 8'h3f);
    tx2Valid = 1'b0;
    // controller never answers the host strobe on the third link
    cmd2Valid = 1'b1;
    for (i = 0; i < 300 && host2Timeout !== 1'b1; i++) @(negedge clk);
    check("host timeout seen", 8'(host2Timeout), 8'h1);
    check("host timeout early", 8'(i >= 64), 8'h1);
    check("host lines released", 8'({linkC.reqLine, linkC.stbLine, linkC.nibLine}), 8'h3f);
    cmd2Valid = 1'b0;
    $display("test timeout done");
    results();
  end

endmodule // cd_controller_host_handshake_port_tb
